// ### hw/tlvi_pkg.sv
// package of constants, states and carriers for the three level vectored interrupt unit
package tlvi_pkg;

  localparam int          NSRC          = 3;
  localparam int          PC_W          = 12;
  localparam int          NIB_W         = 4;
  localparam int          SP_W          = 8;
  localparam int          REG_W         = 8;
  localparam int          ADDR_W        = 12;

  localparam logic [11:0] VEC_RESET     = 12'h000;
  localparam logic [11:0] VEC_FIRST     = 12'h00a;
  localparam logic [11:0] VEC_SECOND    = 12'h00c;
  localparam logic [11:0] VEC_THIRD_DEF = 12'h00e;

  localparam logic [7:0]  STACK_FRAME   = 8'h04;
  localparam logic [2:0]  LOCK_CYCLES   = 3'h4;
  localparam int          ACCEPT_CYCLES = 4;

  localparam logic [11:0] REQ_CLR_ADDR  = 12'h032;
  localparam logic [11:0] STATUS_ADDR   = 12'h030;
  localparam int          CLR_BIT_FIRST = 5;
  localparam int          STAT_PEND_LSB = 0;
  localparam int          STAT_EN_LSB   = 4;

  typedef enum logic [9:0] {
    ST_IDLE = 10'h001,
    ST_ACC1 = 10'h002,
    ST_ACC2 = 10'h004,
    ST_ACC3 = 10'h008,
    ST_ACC4 = 10'h010,
    ST_RET1 = 10'h020,
    ST_RET2 = 10'h040,
    ST_RET3 = 10'h080,
    ST_RET4 = 10'h100,
    ST_RET5 = 10'h200
  } tlvi_state_t;

  typedef struct packed {
    logic              we;
    logic              re;
    logic [SP_W-1:0]   addr;
    logic [NIB_W-1:0]  wdata;
  } tlvi_stack_req_t;

  typedef struct packed {
    logic              load;
    logic [PC_W-1:0]   value;
  } tlvi_pc_load_t;

endpackage

// ### hw/tlvi_unit.sv
// three level vectored interrupt unit: flags, acceptance sequencing, stack push and pop
//
// Decided for this implementation: strobed register access and the register offsets.
module tlvi_unit #(
  parameter logic [11:0] THIRD_VECTOR = tlvi_pkg::VEC_THIRD_DEF
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      resetn_in,
  input  wire logic [tlvi_pkg::NSRC-1:0] src_event_in,
  input  wire logic                      instr_last_in,
  input  wire logic                      edi_exec_in,
  input  wire logic [tlvi_pkg::NSRC-1:0] edi_clr_in,
  input  wire logic [tlvi_pkg::NSRC-1:0] edi_set_in,
  input  wire logic                      return_from_handler_op_exec_in,
  input  wire logic [tlvi_pkg::PC_W-1:0] pc_in,
  input  wire logic [tlvi_pkg::NIB_W-1:0] fs_in,
  input  wire logic [tlvi_pkg::SP_W-1:0] sp_in,
  input  wire logic [tlvi_pkg::NIB_W-1:0] stack_rdata_in,
  input  wire logic [tlvi_pkg::ADDR_W-1:0] reg_addr_in,
  input  wire logic [tlvi_pkg::REG_W-1:0] reg_wdata_in,
  input  wire logic                      reg_wr_in,
  input  wire logic                      reg_rd_in,
  output logic      [tlvi_pkg::REG_W-1:0] reg_rdata_out,
  output tlvi_pkg::tlvi_stack_req_t      stack_req_out,
  output tlvi_pkg::tlvi_pc_load_t        pc_load_out,
  output logic                           fs_load_out,
  output logic      [tlvi_pkg::NIB_W-1:0] fs_value_out,
  output logic                           sp_load_out,
  output logic      [tlvi_pkg::SP_W-1:0] sp_value_out,
  output logic                           busy_out,
  output logic                           accept_out,
  output logic      [tlvi_pkg::NSRC-1:0] accept_src_out,
  output logic      [tlvi_pkg::NSRC-1:0] pending_out,
  output logic      [tlvi_pkg::NSRC-1:0] enable_out
);
  import tlvi_pkg::*;

  if ((THIRD_VECTOR == VEC_RESET) || (THIRD_VECTOR == VEC_FIRST) ||
      (THIRD_VECTOR == VEC_SECOND)) begin : g_vec_check
    $error("third vector must differ from the other vectors");
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [NSRC-1:0] pick_first(input logic [NSRC-1:0] v);
    logic [NSRC-1:0] r;
    r = '0;
    if (v[0]) r = 3'h1;
    else if (v[1]) r = 3'h2;
    else if (v[2]) r = 3'h4;
    return r;
  endfunction

  function automatic logic [PC_W-1:0] vec_of(input logic [NSRC-1:0] s);
    logic [PC_W-1:0] r;
    r = THIRD_VECTOR;
    if (s[0]) r = VEC_FIRST;
    else if (s[1]) r = VEC_SECOND;
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // state and flags

  tlvi_state_t       state_r;
  tlvi_state_t       state_nxt;
  logic [NSRC-1:0]   pend_r;
  logic [NSRC-1:0]   pend_nxt;
  logic [NSRC-1:0]   en_r;
  logic [NSRC-1:0]   en_nxt;
  logic [NSRC-1:0]   sel_r;
  logic [NSRC-1:0]   eligible;
  logic [NSRC-1:0]   best;
  logic [NSRC-1:0]   sw_clr;
  logic [NSRC-1:0]   set_map;
  logic [NSRC-1:0]   clr_map;
  logic [2:0]        lock_r;
  logic              rst_vec_r;
  logic              acc_start;
  logic [SP_W-1:0]   base_sp_r;
  logic [PC_W-1:0]   base_pc_r;
  logic [NIB_W-1:0]  base_fs_r;
  logic [NIB_W-1:0]  pop_fs_r;
  logic [NIB_W-1:0]  pop_hi_r;
  logic [NIB_W-1:0]  pop_mid_r;

  assign eligible  = (pend_r | src_event_in) & en_r;
  assign best      = pick_first(eligible);
  assign set_map   = {edi_set_in[0], edi_set_in[1], edi_set_in[2]};
  assign clr_map   = {edi_clr_in[0], edi_clr_in[1], edi_clr_in[2]};
  assign acc_start = (state_r == ST_IDLE) && instr_last_in && !edi_exec_in &&
                     !return_from_handler_op_exec_in && (lock_r == 3'h0) && !rst_vec_r && (|eligible);

  always_comb begin
    for (int i = 0; i < NSRC; i++) begin
      sw_clr[i] = reg_wr_in && (reg_addr_in == REQ_CLR_ADDR) &&
                  reg_wdata_in[CLR_BIT_FIRST + i];
    end
  end

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE: begin
        if (acc_start) state_nxt = ST_ACC1;
        else if (return_from_handler_op_exec_in && !rst_vec_r) state_nxt = ST_RET1;
      end
      ST_ACC1: state_nxt = ST_ACC2;
      ST_ACC2: state_nxt = ST_ACC3;
      ST_ACC3: state_nxt = ST_ACC4;
      ST_ACC4: state_nxt = ST_IDLE;
      ST_RET1: state_nxt = ST_RET2;
      ST_RET2: state_nxt = ST_RET3;
      ST_RET3: state_nxt = ST_RET4;
      ST_RET4: state_nxt = ST_RET5;
      ST_RET5: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) state_r <= ST_IDLE;
    else state_r <= state_nxt;
  end

  // request flags: a new event wins over any clear in the same cycle
  always_comb begin
    pend_nxt = pend_r & ~sw_clr;
    if (state_r == ST_ACC4) pend_nxt = pend_nxt & ~sel_r;
    pend_nxt = pend_nxt | src_event_in;
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) pend_r <= '0;
    else pend_r <= pend_nxt;
  end

  // enable flags
  always_comb begin
    en_nxt = en_r;
    if (edi_exec_in && (state_r == ST_IDLE)) en_nxt = (en_r & ~clr_map) | set_map;
    if (state_r == ST_ACC4) en_nxt = en_nxt & ~sel_r;
  end

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) en_r <= '0;
    else en_r <= en_nxt;
  end

  // selected source
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sel_r <= '0;
    end else if (acc_start) begin
      sel_r <= best;
    end else if ((state_r == ST_ACC1) && (|(best & (sel_r - 3'h1)))) begin
      sel_r <= best;
    end
  end

  // lockout after acceptance
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) lock_r <= 3'h0;
    else if (state_r == ST_ACC4) lock_r <= LOCK_CYCLES;
    else if (lock_r != 3'h0) lock_r <= lock_r - 3'h1;
  end

  // reset vector request after reset release
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) rst_vec_r <= 1'b1;
    else rst_vec_r <= 1'b0;
  end

  // captured context
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      base_sp_r <= '0;
      base_pc_r <= '0;
      base_fs_r <= '0;
    end else if ((state_r == ST_IDLE) && (state_nxt != ST_IDLE)) begin
      base_sp_r <= sp_in;
      base_pc_r <= pc_in;
      base_fs_r <= fs_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // stack port

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      stack_req_out <= '0;
    end else begin
      stack_req_out <= '0;
      unique case (state_nxt)
        ST_ACC1: begin
          stack_req_out.we    <= 1'b1;
          stack_req_out.addr  <= sp_in - 8'h01;
          stack_req_out.wdata <= pc_in[3:0];
        end
        ST_ACC2: begin
          stack_req_out.we    <= 1'b1;
          stack_req_out.addr  <= base_sp_r - 8'h02;
          stack_req_out.wdata <= base_pc_r[7:4];
        end
        ST_ACC3: begin
          stack_req_out.we    <= 1'b1;
          stack_req_out.addr  <= base_sp_r - 8'h03;
          stack_req_out.wdata <= base_pc_r[11:8];
        end
        ST_ACC4: begin
          stack_req_out.we    <= 1'b1;
          stack_req_out.addr  <= base_sp_r - STACK_FRAME;
          stack_req_out.wdata <= base_fs_r;
        end
        ST_RET1: begin
          stack_req_out.re    <= 1'b1;
          stack_req_out.addr  <= sp_in;
        end
        ST_RET2: begin
          stack_req_out.re    <= 1'b1;
          stack_req_out.addr  <= base_sp_r + 8'h01;
        end
        ST_RET3: begin
          stack_req_out.re    <= 1'b1;
          stack_req_out.addr  <= base_sp_r + 8'h02;
        end
        ST_RET4: begin
          stack_req_out.re    <= 1'b1;
          stack_req_out.addr  <= base_sp_r + 8'h03;
        end
        default: stack_req_out <= '0;
      endcase
    end
  end

  // popped nibbles, each arriving the cycle after its read
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pop_fs_r  <= '0;
      pop_hi_r  <= '0;
      pop_mid_r <= '0;
    end else begin
      if (state_r == ST_RET2) pop_fs_r <= stack_rdata_in;
      if (state_r == ST_RET3) pop_hi_r <= stack_rdata_in;
      if (state_r == ST_RET4) pop_mid_r <= stack_rdata_in;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // loads towards the sequencer

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      pc_load_out    <= '0;
      fs_load_out    <= 1'b0;
      fs_value_out   <= '0;
      sp_load_out    <= 1'b0;
      sp_value_out   <= '0;
      accept_out     <= 1'b0;
      accept_src_out <= '0;
    end else begin
      pc_load_out.load <= 1'b0;
      fs_load_out      <= 1'b0;
      sp_load_out      <= 1'b0;
      accept_out       <= 1'b0;
      if (rst_vec_r) begin
        pc_load_out.load  <= 1'b1;
        pc_load_out.value <= VEC_RESET;
      end else if (state_r == ST_ACC4) begin
        pc_load_out.load  <= 1'b1;
        pc_load_out.value <= vec_of(sel_r);
        sp_load_out       <= 1'b1;
        sp_value_out      <= base_sp_r - STACK_FRAME;
        accept_out        <= 1'b1;
        accept_src_out    <= sel_r;
      end else if (state_r == ST_RET5) begin
        pc_load_out.load  <= 1'b1;
        pc_load_out.value <= {pop_hi_r, pop_mid_r, stack_rdata_in};
        fs_load_out       <= 1'b1;
        fs_value_out      <= pop_fs_r;
        sp_load_out       <= 1'b1;
        sp_value_out      <= base_sp_r + STACK_FRAME;
      end
    end
  end

  assign busy_out    = (state_r != ST_IDLE);
  assign pending_out = pend_r;
  assign enable_out  = en_r;

  ////////////////////////////////////////////////////////////////////////////////
  // register port

  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      reg_rdata_out <= '0;
    end else begin
      reg_rdata_out <= '0;
      if (reg_rd_in && (reg_addr_in == STATUS_ADDR)) begin
        reg_rdata_out[STAT_PEND_LSB +: NSRC] <= pend_r;
        reg_rdata_out[STAT_EN_LSB +: NSRC]   <= en_r;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // checks

  AST_VECTOR: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    accept_out |-> pc_load_out.load && (pc_load_out.value == vec_of(accept_src_out)))
    else $error("vector does not match accepted source");

  AST_ELIGIBLE: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    acc_start |-> (|(best & en_r)) && (|(best & (pend_r | src_event_in))))
    else $error("acceptance started without request and enable");

  AST_PRIORITY: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_ACC2) |-> (($past(eligible) & (sel_r - 3'h1)) == 3'h0))
    else $error("higher priority source was passed over");

  AST_OTHERS_KEPT: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_ACC4) |=> ((en_r & ~$past(sel_r)) == ($past(en_r) & ~$past(sel_r))))
    else $error("other enable flags changed on acceptance");

  AST_REQ_SET: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (|src_event_in) |=> ((pend_r & $past(src_event_in)) == $past(src_event_in)))
    else $error("request flag not set by event");

  AST_SW_CLEAR: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (|(sw_clr & ~src_event_in)) |=> ((pend_r & $past(sw_clr & ~src_event_in)) == 3'h0))
    else $error("request flag not cleared by software");

  AST_EDI: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (edi_exec_in && (state_r == ST_IDLE)) |=>
      (en_r == (($past(en_r) & ~$past(clr_map)) | $past(set_map))))
    else $error("enable-disable op mapped wrongly");

  AST_PUSH_ORDER: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_ACC1) |-> stack_req_out.we ##1 stack_req_out.we ##1 stack_req_out.we
      ##1 stack_req_out.we ##1 pc_load_out.load)
    else $error("push did not precede the branch");

  AST_ACC_CLEAR: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_ACC4) |=> ((en_r & $past(sel_r)) == 3'h0) &&
      ((pend_r & $past(sel_r & ~src_event_in)) == 3'h0))
    else $error("accepted source flags not cleared");

  AST_SP_PUSH: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    acc_start |-> ##4 ##1 (sp_load_out && (sp_value_out == $past(sp_in, 5) - 8'h04)))
    else $error("stack pointer not lowered by four");

  AST_POP: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_RET1) |-> stack_req_out.re && (stack_req_out.addr == base_sp_r)
      ##5 (sp_load_out && fs_load_out && (sp_value_out == base_sp_r + 8'h04)))
    else $error("return pop sequence wrong");

  AST_LATENCY: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    acc_start |-> ##1 !accept_out [*4] ##1 accept_out)
    else $error("acceptance latency wrong");

  AST_BOUNDARY: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    acc_start |-> instr_last_in && !edi_exec_in)
    else $error("acceptance inside an instruction or after enable-disable op");

  AST_LOCKOUT: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    accept_out |-> !acc_start [*4])
    else $error("acceptance during lockout");

  AST_NO_DISPLACE: assert property (@(posedge core_clk_in) disable iff (!resetn_in)
    (state_r == ST_ACC2) |=> $stable(sel_r) ##1 $stable(sel_r))
    else $error("selection changed after first acceptance cycle");

endmodule // tlvi_unit

// ### sim/tlvi_cpu_model.sv
// stack ram and stack pointer of the cpu core that faces the interrupt unit
module tlvi_cpu_model #(
  parameter logic [7:0] SP_INIT = 8'h80
) (
  input  wire logic                      core_clk_in,
  input  wire logic                      resetn_in,
  input  wire tlvi_pkg::tlvi_stack_req_t req_in,
  input  wire logic                      sp_load_in,
  input  wire logic [7:0]                sp_value_in,
  output logic      [7:0]                sp_out,
  output logic      [3:0]                rdata_out
);
  timeunit 1ns;
  timeprecision 1ps;
  import tlvi_pkg::*;
  logic [3:0] mem [256];
  ////////////////////////////////////////////////////////////////////////
  // nibble ram, read data valid only in the cycle after the read strobe
  always_ff @(posedge core_clk_in) begin
    if (req_in.we) begin
      mem[req_in.addr] <= req_in.wdata;
    end
    if (!resetn_in) begin
      rdata_out <= 4'h0;
    end else if (req_in.re) begin
      rdata_out <= mem[req_in.addr];
    end else begin
      rdata_out <= ~rdata_out;
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // stack pointer follows the loads of the unit
  always_ff @(posedge core_clk_in) begin
    if (!resetn_in) begin
      sp_out <= SP_INIT;
    end else if (sp_load_in) begin
      sp_out <= sp_value_in;
    end
  end
endmodule // tlvi_cpu_model

// ### sim/tlvi_tb.sv
// testbench of the three level vectored interrupt unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import tlvi_pkg::*;
  localparam logic [11:0] VEC3 = 12'h0e2;
  logic            core_clk = 1'b0;
  logic            resetn   = 1'b0;
  logic [2:0]      src_ev   = 3'h0;
  logic            last     = 1'b1;
  logic            enable_disable_op      = 1'b0;
  logic [2:0]      edi_clr  = 3'h0;
  logic [2:0]      edi_set  = 3'h0;
  logic            return_from_handler_op     = 1'b0;
  logic [11:0]     pc       = 12'h5a3;
  logic [3:0]      fs       = 4'h9;
  logic [11:0]     ra       = 12'h000;
  logic [7:0]      wd       = 8'h00;
  logic            wr       = 1'b0;
  logic            rd       = 1'b0;
  logic [7:0]      sp, rdat, spv;
  logic [3:0]      srd, fsv;
  tlvi_stack_req_t sreq;
  tlvi_pc_load_t   pcl;
  logic            fsl, spl, busy, acc;
  logic [2:0]      asrc, pend, en;
  int              err_total = 0;
  int              checks_done = 0;
  always #20 core_clk = ~core_clk;
  tlvi_unit #(.THIRD_VECTOR(VEC3)) uut (
    .core_clk_in(core_clk), .resetn_in(resetn), .src_event_in(src_ev),
    .instr_last_in(last), .edi_exec_in(enable_disable_op), .edi_clr_in(edi_clr),
    .edi_set_in(edi_set), .return_from_handler_op_exec_in(return_from_handler_op), .pc_in(pc), .fs_in(fs),
    .sp_in(sp), .stack_rdata_in(srd), .reg_addr_in(ra), .reg_wdata_in(wd),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdat), .stack_req_out(sreq),
    .pc_load_out(pcl), .fs_load_out(fsl), .fs_value_out(fsv), .sp_load_out(spl),
    .sp_value_out(spv), .busy_out(busy), .accept_out(acc), .accept_src_out(asrc),
    .pending_out(pend), .enable_out(en)
  );
  tlvi_cpu_model cpu (
    .core_clk_in(core_clk), .resetn_in(resetn), .req_in(sreq),
    .sp_load_in(spl), .sp_value_in(spv), .sp_out(sp), .rdata_out(srd)
  );
  ////////////////////////////////////////////////////////////////////////
  // helpers
  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic complete_run;
    if (err_total == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic reg_wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge core_clk);
    ra <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask
  task automatic reg_rd(input logic [11:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    ra <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    #1 chk(12'(rdat), 12'(exp));
  endtask
  task automatic edi_op(input logic [2:0] c, input logic [2:0] s, input logic [2:0] exp);
    @(posedge core_clk);
    enable_disable_op <= 1'b1;
    edi_clr <= c;
    edi_set <= s;
    @(posedge core_clk);
    enable_disable_op <= 1'b0;
    edi_clr <= 3'h0;
    edi_set <= 3'h0;
    #1 chk(12'(en), 12'(exp));
  endtask
  // one instruction cycle: factors, enable-disable op, final-cycle flag
  task automatic step(input logic [2:0] s, input logic e, input logic l);
    @(posedge core_clk);
    src_ev <= s;
    enable_disable_op <= e;
    last <= l;
  endtask
  // cycles from the last driven cycle to the accept pulse, and its vector
  task automatic wait_acc(input int n_exp, input logic [11:0] vec);
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      src_ev <= 3'h0;
      enable_disable_op <= 1'b0;
      last <= 1'b1;
      #1 n++;
    end while (acc !== 1'b1 && n < 30);
    chk(12'(n), 12'(n_exp));
    chk(pcl.value, vec);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // watchdog
  initial begin
    #200us;
    err_total++;
    complete_run();
  end
  ////////////////////////////////////////////////////////////////////////
  // tests
  initial begin
    logic [7:0] s0;
    int         n;
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    #1 chk(12'(pcl.load), 12'h001);
    chk(pcl.value, VEC_RESET);
    chk(12'({pend, en}), 12'h000);
    edi_op(3'h0, 3'b100, 3'b001);
    edi_op(3'h0, 3'b011, 3'b111);
    // plain acceptance of the second source, push and return
    s0 = sp;
    step(3'b010, 1'b0, 1'b1);
    wait_acc(5, VEC_SECOND);
    chk(12'(asrc), 12'h002);
    chk(12'({pend, en}), 12'h005);
    chk(12'(spv), 12'(s0 - 8'h04));
    chk({cpu.mem[s0-8'h01], cpu.mem[s0-8'h02], cpu.mem[s0-8'h03]}, 12'h3a5);
    chk(12'(cpu.mem[s0-8'h04]), 12'h009);
    @(posedge core_clk);
    return_from_handler_op <= 1'b1;
    @(posedge core_clk);
    return_from_handler_op <= 1'b0;
    #1 chk(12'(busy), 12'h001);
    n = 0;
    do begin
      @(posedge core_clk);
      #1 n++;
    end while (pcl.load !== 1'b1 && n < 12);
    chk(pcl.value, pc);
    chk(12'({fsl, fsv}), 12'h019);
    @(posedge core_clk);
    #1 chk(12'(sp), 12'(s0));
    // three cycle instruction, then enable-disable op followed by a two cycle one
    edi_op(3'h0, 3'b010, 3'b111);
    step(3'b010, 1'b0, 1'b0);
    step(3'b000, 1'b0, 1'b0);
    step(3'b000, 1'b0, 1'b1);
    wait_acc(5, VEC_SECOND);
    repeat (8) @(posedge core_clk);
    edi_op(3'h0, 3'b010, 3'b111);
    step(3'b010, 1'b1, 1'b1);
    step(3'b000, 1'b0, 1'b0);
    step(3'b000, 1'b0, 1'b1);
    wait_acc(5, VEC_SECOND);
    // simultaneous factors, then nesting after each lockout
    repeat (8) @(posedge core_clk);
    edi_op(3'h0, 3'b010, 3'b111);
    step(3'b111, 1'b0, 1'b1);
    wait_acc(5, VEC_FIRST);
    chk(12'(en), 12'h006);
    wait_acc(9, VEC_SECOND);
    wait_acc(9, VEC3);
    chk(12'({pend, en}), 12'h000);
    // higher factor in the first and in the second acceptance cycle
    repeat (8) @(posedge core_clk);
    edi_op(3'h0, 3'b111, 3'b111);
    step(3'b100, 1'b0, 1'b1);
    step(3'b001, 1'b0, 1'b1);
    wait_acc(4, VEC_FIRST);
    wait_acc(9, VEC3);
    repeat (8) @(posedge core_clk);
    edi_op(3'b010, 3'b101, 3'b101);
    step(3'b100, 1'b0, 1'b1);
    step(3'b000, 1'b0, 1'b1);
    step(3'b001, 1'b0, 1'b1);
    wait_acc(3, VEC3);
    wait_acc(9, VEC_FIRST);
    // disabled source stays pending until software clears it
    repeat (8) @(posedge core_clk);
    edi_op(3'b010, 3'b101, 3'b101);
    step(3'b010, 1'b0, 1'b1);
    repeat (8) begin
      @(posedge core_clk);
      src_ev <= 3'h0;
      #1 chk(12'(acc), 12'h000);
    end
    chk(12'(pend), 12'h002);
    reg_rd(STATUS_ADDR, 8'h52);
    reg_wr(REQ_CLR_ADDR, 8'h40);
    reg_rd(STATUS_ADDR, 8'h50);
    reg_rd(REQ_CLR_ADDR, 8'h00);
    reg_rd(12'h031, 8'h00);
    complete_run();
  end
endmodule // tb
